// ### rawsk_defines.svh
// constants for the raw socket engine: register map, codes, field layout
// assumes inclusion by the package, the socket, its checker and the bench
`ifndef RAWSK_DEFINES_SVH
`define RAWSK_DEFINES_SVH
`define RAWSK_A_MODE 12'h000
`define RAWSK_A_CMD 12'h004
`define RAWSK_A_IRQ 12'h008
`define RAWSK_A_STATE 12'h00C
`define RAWSK_A_PROTO 12'h010
`define RAWSK_A_DIP 12'h014
`define RAWSK_A_TXWR 12'h018
`define RAWSK_A_TXRD 12'h01C
`define RAWSK_A_RXRD 12'h020
`define RAWSK_A_RXSIZE 12'h024
`define RAWSK_A_TXWIN 2'h1
`define RAWSK_A_RXWIN 2'h2
`define RAWSK_MODE_SEL 3:0
`define RAWSK_MODE_MF 6
`define RAWSK_MODE_IP_RAW_MODE 4'h3
`define RAWSK_MODE_MAC_RAW_MODE 4'h4
`define RAWSK_CMD_NONE 8'h00
`define RAWSK_CMD_OPEN 8'h01
`define RAWSK_CMD_CLOSE 8'h10
`define RAWSK_CMD_SEND 8'h20
`define RAWSK_CMD_RECV 8'h40
`define RAWSK_ST_CLOSED 8'h00
`define RAWSK_ST_IP_RAW_MODE 8'h32
`define RAWSK_ST_MAC_RAW_MODE 8'h42
`define RAWSK_IRQ_SEND 0
`define RAWSK_IRQ_RECV 1
`define RAWSK_PROTO_ICMP 8'h01
`define RAWSK_PROTO_IGMP 8'h02
`define RAWSK_PROTO_TCP 8'h06
`define RAWSK_PROTO_UDP 8'h11
`define RAWSK_MEM_DEPTH 17'h00100
`define RAWSK_AW 8
`define RAWSK_MIN_FRAME 16'h003C
`define RAWSK_IP_HDR_LEN 3'h6
`define RAWSK_MAC_HDR_LEN 3'h2
`define RAWSK_TX_HEAD_LAST 3'h4
`endif

// ### rawsk_pkg.sv
// types shared by the raw socket engine and its surroundings
// assumes rawsk_defines.svh is on the include path
`include "rawsk_defines.svh"
package rawsk_pkg;
    typedef struct packed {
        logic [31:0] src_ip;
        logic [7:0] proto;
        logic [15:0] length;
        logic fragment;
        logic to_station;
        logic broadcast;
    } rawsk_rx_meta_type;
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } rawsk_beat_type;
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1, TX_HEAD = 4'h2, TX_BODY = 4'h4, TX_PAD = 4'h8
    } rawsk_tx_state_type;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1, RX_HDR = 4'h2, RX_DATA = 4'h4, RX_DROP = 4'h8
    } rawsk_rx_state_type;
endpackage

// ### rawsk_socket.sv
// raw socket engine: one socket in ip-raw or mac-raw mode, apb registers,
// 256-byte tx and rx memories, byte streams toward the mac on pclk.
// Overview of operation
// - ip-raw carries only datagrams whose protocol number matches the socket.
// - ip-raw refuses protocol numbers 0x06 and 0x11.
// - mode select 0x03 then open enters ip-raw.
// - successful ip-raw open shows the ip-raw state, else host retries.
// - ip-raw receive stores 4-byte source ip, 2-byte length, then payload.
// - datagrams too big for free rx memory, or fragmented, are dropped.
// - ip-raw send uses udp pointer/command flow without ports.
// - icmp echo and igmp stay with the hardware stack otherwise.
// - frames not taken here go on to the other sockets' stack.
// - mac-raw passes whole frames with no protocol processing.
// - mode 0x04 then open on socket zero enters mac-raw.
// - mac-raw needs no address, port or protocol configuration.
// - send completion sets send_done_flag; host clears by writing one.
// - send transmits bytes between tx read and write pointers.
// - command register returns to 0x00 once a command completes.
// - mac-raw frames shorter than 60 bytes are zero padded.
// - mode bit 6 filters mac-raw receive to station or broadcast.
`timescale 1ns/1ns
`default_nettype none
`include "rawsk_defines.svh"
module rawsk_socket #(
    parameter logic [2:0] SOCKET_INDEX = 3'h0
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit stream toward the mac
    output logic tx_valid,
    output rawsk_pkg::rawsk_beat_type tx_beat,
    input wire logic tx_ready,
    // receive stream from the mac
    input wire logic rx_valid,
    input wire rawsk_pkg::rawsk_beat_type rx_beat,
    input wire rawsk_pkg::rawsk_rx_meta_type rx_meta,
    output logic rx_ready,
    // frame left for the hardware stack, one-cycle pulse
    output logic hw_stack_take
);
    logic [7:0] mode_q, mode_d, cmd_q, cmd_d, state_q, state_d, proto_q, proto_d;
    logic [1:0] irq_q, irq_d;
    logic [31:0] dip_q, dip_d, prdata_q, prdata_d, send_ip_q, send_ip_d;
    logic [15:0] txwr_q, txwr_d, txrd_q, txrd_d, rxrd_q, rxrd_d, rxwr_q, rxwr_d;
    logic [15:0] cnt_q, cnt_d, rxused, rxlen;
    logic [2:0] hcnt_q, hcnt_d, hlen;
    logic [47:0] hdr_q, hdr_d;
    logic tx_valid_q, tx_valid_d, take_q, take_d, slverr_q, slverr_d;
    rawsk_pkg::rawsk_beat_type beat_q, beat_d;
    rawsk_pkg::rawsk_tx_state_type txs_q, txs_d;
    rawsk_pkg::rawsk_rx_state_type rxs_q, rxs_d;
    logic [7:0] tx_mem [0:`RAWSK_MEM_DEPTH-1];
    logic [7:0] rx_mem [0:`RAWSK_MEM_DEPTH-1];
    logic tx_we, rx_we, setup, wr_acc, is_ip, is_mac, accept, tx_adv, send_done;
    logic [`RAWSK_AW-1:0] tx_wa, rx_wa;
    logic [7:0] tx_wd, rx_wd;

    // read data is latched in the setup cycle, so every access ends at once
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = slverr_q;
    assign tx_valid = tx_valid_q;
    assign tx_beat = beat_q;
    assign hw_stack_take = take_q;
    assign rx_ready = (rxs_q == rawsk_pkg::RX_DATA) || (rxs_q == rawsk_pkg::RX_DROP);
    assign is_ip = state_q == `RAWSK_ST_IP_RAW_MODE;
    assign is_mac = state_q == `RAWSK_ST_MAC_RAW_MODE;
    assign rxused = rxwr_q - rxrd_q;
    assign tx_adv = !tx_valid_q || tx_ready;
    assign hlen = is_ip ? `RAWSK_IP_HDR_LEN : `RAWSK_MAC_HDR_LEN;

    always_comb begin
        // frame acceptance decided on the first beat
        accept = 1'b0;
        if (is_ip) begin
            accept = (rx_meta.proto == proto_q) && !rx_meta.fragment;
        end else if (is_mac) begin
            accept = !mode_q[`RAWSK_MODE_MF] || rx_meta.to_station
                || rx_meta.broadcast;
        end
        rxlen = rx_meta.length;
        // header plus payload must fit the free space, else drop
        if ({1'b0, rxlen} + {14'h0000, hlen} > `RAWSK_MEM_DEPTH - {1'b0, rxused}) begin
            accept = 1'b0;
        end
    end

    always_comb begin
        mode_d = mode_q;
        cmd_d = cmd_q;
        state_d = state_q;
        proto_d = proto_q;
        dip_d = dip_q;
        txwr_d = txwr_q;
        rxrd_d = rxrd_q;
        irq_d = irq_q;
        prdata_d = prdata_q;
        slverr_d = 1'b0;
        tx_we = 1'b0;
        tx_wa = paddr[`RAWSK_AW+1:2];
        tx_wd = pwdata[7:0];
        if (setup) begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                `RAWSK_A_MODE: prdata_d[7:0] = mode_q;
                `RAWSK_A_CMD: prdata_d[7:0] = cmd_q;
                `RAWSK_A_IRQ: prdata_d[1:0] = irq_q;
                `RAWSK_A_STATE: prdata_d[7:0] = state_q;
                `RAWSK_A_PROTO: prdata_d[7:0] = proto_q;
                `RAWSK_A_DIP: prdata_d = dip_q;
                `RAWSK_A_TXWR: prdata_d[15:0] = txwr_q;
                `RAWSK_A_TXRD: prdata_d[15:0] = txrd_q;
                `RAWSK_A_RXRD: prdata_d[15:0] = rxrd_q;
                `RAWSK_A_RXSIZE: prdata_d[15:0] = rxused;
                default: begin
                    if (paddr[11:10] == `RAWSK_A_RXWIN) begin
                        prdata_d[7:0] = rx_mem[paddr[`RAWSK_AW+1:2]];
                    end else if (paddr[11:10] != `RAWSK_A_TXWIN) begin
                        slverr_d = 1'b1;
                    end
                end
            endcase
        end else if (psel && penable) begin
            slverr_d = slverr_q;
        end
        if (wr_acc) begin
            unique case (paddr)
                `RAWSK_A_MODE: mode_d = pwdata[7:0];
                // a command is refused while the previous one is pending
                `RAWSK_A_CMD: cmd_d = (cmd_q == `RAWSK_CMD_NONE) ? pwdata[7:0] : cmd_q;
                `RAWSK_A_PROTO: proto_d = pwdata[7:0];
                `RAWSK_A_DIP: dip_d = pwdata;
                `RAWSK_A_TXWR: txwr_d = pwdata[15:0];
                `RAWSK_A_RXRD: rxrd_d = pwdata[15:0];
                `RAWSK_A_IRQ: irq_d = irq_q & ~pwdata[1:0];
                default: tx_we = paddr[11:10] == `RAWSK_A_TXWIN;
            endcase
        end
        if (!wr_acc || paddr != `RAWSK_A_CMD) begin
            unique case (cmd_q)
                `RAWSK_CMD_NONE: cmd_d = cmd_q;
                `RAWSK_CMD_OPEN: begin
                    cmd_d = `RAWSK_CMD_NONE;
                    state_d = `RAWSK_ST_CLOSED;
                    if (mode_q[`RAWSK_MODE_SEL] == `RAWSK_MODE_IP_RAW_MODE
                        && proto_q != `RAWSK_PROTO_TCP
                        && proto_q != `RAWSK_PROTO_UDP) begin
                        state_d = `RAWSK_ST_IP_RAW_MODE;
                    end
                    if (mode_q[`RAWSK_MODE_SEL] == `RAWSK_MODE_MAC_RAW_MODE
                        && SOCKET_INDEX == 3'h0) begin
                        state_d = `RAWSK_ST_MAC_RAW_MODE;
                    end
                end
                `RAWSK_CMD_CLOSE: begin
                    cmd_d = `RAWSK_CMD_NONE;
                    state_d = `RAWSK_ST_CLOSED;
                end
                `RAWSK_CMD_SEND: begin
                    if (send_done || !(is_ip || is_mac)) begin
                        cmd_d = `RAWSK_CMD_NONE;
                    end
                end
                default: cmd_d = `RAWSK_CMD_NONE;
            endcase
        end
        // set wins over a clear in the same cycle
        if (send_done) begin
            irq_d[`RAWSK_IRQ_SEND] = 1'b1;
        end
        if (rx_valid && rx_ready && rx_beat.last && rxs_q == rawsk_pkg::RX_DATA) begin
            irq_d[`RAWSK_IRQ_RECV] = 1'b1;
        end
    end

    always_comb begin
        txs_d = txs_q;
        txrd_d = txrd_q;
        cnt_d = cnt_q;
        send_ip_d = send_ip_q;
        tx_valid_d = tx_valid_q;
        beat_d = beat_q;
        send_done = 1'b0;
        if (tx_adv) begin
            tx_valid_d = 1'b0;
        end
        unique case (txs_q)
            rawsk_pkg::TX_IDLE: begin
                cnt_d = 16'h0000;
                if (cmd_q == `RAWSK_CMD_SEND && (is_ip || is_mac)) begin
                    send_ip_d = dip_q;
                    txs_d = is_ip ? rawsk_pkg::TX_HEAD : rawsk_pkg::TX_BODY;
                end
            end
            rawsk_pkg::TX_HEAD: if (tx_adv) begin
                // destination ip then protocol number lead the datagram
                tx_valid_d = 1'b1;
                beat_d.last = 1'b0;
                beat_d.data = (cnt_q[2:0] == `RAWSK_TX_HEAD_LAST) ? proto_q
                    : send_ip_q[31:24];
                send_ip_d = {send_ip_q[23:0], 8'h00};
                cnt_d = (cnt_q[2:0] == `RAWSK_TX_HEAD_LAST) ? 16'h0000 : cnt_q + 16'h0001;
                if (cnt_q[2:0] == `RAWSK_TX_HEAD_LAST) begin
                    txs_d = rawsk_pkg::TX_BODY;
                end
            end
            rawsk_pkg::TX_BODY: if (tx_adv) begin
                if (txrd_q == txwr_q) begin
                    txs_d = rawsk_pkg::TX_IDLE;
                    send_done = 1'b1;
                end else begin
                    tx_valid_d = 1'b1;
                    beat_d.data = tx_mem[txrd_q[`RAWSK_AW-1:0]];
                    txrd_d = txrd_q + 16'h0001;
                    cnt_d = cnt_q + 16'h0001;
                    beat_d.last = (txrd_q + 16'h0001 == txwr_q)
                        && !(is_mac && cnt_q + 16'h0001 < `RAWSK_MIN_FRAME);
                    if (txrd_q + 16'h0001 == txwr_q && !beat_d.last) begin
                        txs_d = rawsk_pkg::TX_PAD;
                    end
                end
            end
            rawsk_pkg::TX_PAD: if (tx_adv) begin
                tx_valid_d = 1'b1;
                beat_d.data = 8'h00;
                cnt_d = cnt_q + 16'h0001;
                beat_d.last = cnt_q + 16'h0001 == `RAWSK_MIN_FRAME;
                if (beat_d.last) begin
                    txs_d = rawsk_pkg::TX_BODY;
                end
            end
        endcase
        if (cmd_q == `RAWSK_CMD_CLOSE) begin
            txs_d = rawsk_pkg::TX_IDLE;
        end
    end

    always_comb begin
        rxs_d = rxs_q;
        rxwr_d = rxwr_q;
        hcnt_d = hcnt_q;
        hdr_d = hdr_q;
        take_d = 1'b0;
        rx_we = 1'b0;
        rx_wa = rxwr_q[`RAWSK_AW-1:0];
        rx_wd = rx_beat.data;
        unique case (rxs_q)
            rawsk_pkg::RX_IDLE: if (rx_valid) begin
                hcnt_d = 3'h0;
                hdr_d = is_ip ? {rx_meta.src_ip, rx_meta.length}
                    : {rx_meta.length, 32'h0000_0000};
                rxs_d = accept ? rawsk_pkg::RX_HDR : rawsk_pkg::RX_DROP;
                // icmp and igmp not taken here stay with the hardware stack
                take_d = !accept;
            end
            rawsk_pkg::RX_HDR: begin
                rx_we = 1'b1;
                rx_wd = hdr_q[47:40];
                hdr_d = {hdr_q[39:0], 8'h00};
                rxwr_d = rxwr_q + 16'h0001;
                hcnt_d = hcnt_q + 3'h1;
                if (hcnt_q + 3'h1 == hlen) begin
                    rxs_d = rawsk_pkg::RX_DATA;
                end
            end
            rawsk_pkg::RX_DATA: if (rx_valid) begin
                rx_we = 1'b1;
                rxwr_d = rxwr_q + 16'h0001;
                if (rx_beat.last) begin
                    rxs_d = rawsk_pkg::RX_IDLE;
                end
            end
            rawsk_pkg::RX_DROP: if (rx_valid && rx_beat.last) begin
                rxs_d = rawsk_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 8'h00;
            cmd_q <= `RAWSK_CMD_NONE;
            state_q <= `RAWSK_ST_CLOSED;
            proto_q <= 8'h00;
            irq_q <= 2'h0;
            dip_q <= 32'h0000_0000;
            prdata_q <= 32'h0000_0000;
            send_ip_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
            txwr_q <= 16'h0000;
            txrd_q <= 16'h0000;
            rxrd_q <= 16'h0000;
            rxwr_q <= 16'h0000;
            cnt_q <= 16'h0000;
            hcnt_q <= 3'h0;
            hdr_q <= 48'h0000_0000_0000;
            tx_valid_q <= 1'b0;
            take_q <= 1'b0;
            beat_q <= '0;
            txs_q <= rawsk_pkg::TX_IDLE;
            rxs_q <= rawsk_pkg::RX_IDLE;
        end else if (ce) begin
            mode_q <= mode_d;
            cmd_q <= cmd_d;
            state_q <= state_d;
            proto_q <= proto_d;
            irq_q <= irq_d;
            dip_q <= dip_d;
            prdata_q <= prdata_d;
            send_ip_q <= send_ip_d;
            slverr_q <= slverr_d;
            txwr_q <= txwr_d;
            txrd_q <= txrd_d;
            rxrd_q <= rxrd_d;
            rxwr_q <= rxwr_d;
            cnt_q <= cnt_d;
            hcnt_q <= hcnt_d;
            hdr_q <= hdr_d;
            tx_valid_q <= tx_valid_d;
            take_q <= take_d;
            beat_q <= beat_d;
            txs_q <= txs_d;
            rxs_q <= rxs_d;
        end
    end

    // memories carry no reset; contents are defined only once written
    always_ff @(posedge pclk) begin
        if (ce && tx_we) begin
            tx_mem[tx_wa] <= tx_wd;
        end
        if (ce && rx_we) begin
            rx_mem[rx_wa] <= rx_wd;
        end
    end
endmodule
`default_nettype wire

// ### rawsk_socket_asserts.sv
// port checker for rawsk_socket, bound below
// assumes the bench leaves an idle cycle after each apb transfer
`timescale 1ns/1ns
`default_nettype none
`include "rawsk_defines.svh"
module rawsk_socket_asserts (
    // clock and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // streams
    input wire logic tx_valid,
    input wire rawsk_pkg::rawsk_beat_type tx_beat,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire rawsk_pkg::rawsk_beat_type rx_beat,
    input wire rawsk_pkg::rawsk_rx_meta_type rx_meta,
    input wire logic rx_ready,
    input wire logic hw_stack_take
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] mode_q, mode_d;
    logic [7:0] proto_q, proto_d, txn_q, txn_d;
    logic busy_q, busy_d, wr, go, ip_ok, ip_bad, frag;
    always_comb begin
        wr = psel && penable && pwrite && ce;
        go = tx_valid && tx_ready && ce;
        mode_d = (wr && paddr == `RAWSK_A_MODE) ? pwdata[3:0] : mode_q;
        proto_d = (wr && paddr == `RAWSK_A_PROTO) ? pwdata[7:0] : proto_q;
        busy_d = (busy_q || rx_valid) && !(rx_valid && rx_ready && rx_beat.last);
        txn_d = !go ? txn_q : (tx_beat.last ? 8'h00 : txn_q + 8'h01);
        ip_bad = proto_q == `RAWSK_PROTO_TCP || proto_q == `RAWSK_PROTO_UDP;
        ip_ok = mode_q == `RAWSK_MODE_IP_RAW_MODE && !ip_bad;
        // fragments are only refused in ip-raw; mac-raw passes them on
        frag = rx_valid && !busy_q && rx_meta.fragment && mode_q == `RAWSK_MODE_IP_RAW_MODE;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode_q, proto_q, txn_q, busy_q} <= '0;
        end else begin
            {mode_q, proto_q, txn_q, busy_q} <= {mode_d, proto_d, txn_d, busy_d};
        end
    end
    sequence s_open(c);
        c && wr && paddr == `RAWSK_A_CMD && pwdata[7:0] == `RAWSK_CMD_OPEN;
    endsequence
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    property p_state(c, st);
        s_open(c) ##[2:5] s_rd(`RAWSK_A_STATE) |=> prdata[7:0] == st;
    endproperty
    AST_CMD_ZERO: assert property (s_open(1'b1) ##2 s_rd(`RAWSK_A_CMD) |=> prdata == 32'h0)
        else $error("command not cleared");
    AST_IP_OPEN: assert property (p_state(ip_ok, `RAWSK_ST_IP_RAW_MODE))
        else $error("ip-raw open state wrong");
    AST_BAD_PROTO: assert property (p_state(mode_q == `RAWSK_MODE_IP_RAW_MODE && ip_bad, 8'h00))
        else $error("tcp or udp number opened");
    AST_MAC_OPEN: assert property (p_state(mode_q == `RAWSK_MODE_MAC_RAW_MODE, `RAWSK_ST_MAC_RAW_MODE))
        else $error("mac-raw open state wrong");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat))
        else $error("tx beat dropped while stalled");
    AST_TAKE_PULSE: assert property (hw_stack_take |-> $past(rx_valid) ##1 !hw_stack_take)
        else $error("stack hand-off not a single pulse");
    AST_FRAG_DROP: assert property (frag |=> hw_stack_take)
        else $error("fragment not dropped");
    AST_MIN_FRAME: assert property (go && tx_beat.last && mode_q == 4'h4 |-> txn_q >= 8'h3B)
        else $error("mac-raw frame under 60 bytes");
endmodule
bind rawsk_socket rawsk_socket_asserts rawsk_socket_asserts_i (.*);
`default_nettype wire

// ### rawsk_mac_model.sv
// network side model: sinks the tx stream, plays frames into rx
// assumes the socket's pclk; tb calls frame() right after an edge
`timescale 1ns/1ns
`default_nettype none
module rawsk_mac_model (
    // clock and pacing
    input wire logic pclk,
    input wire logic slow,
    // transmit stream
    input wire logic tx_valid,
    input wire rawsk_pkg::rawsk_beat_type tx_beat,
    output logic tx_ready,
    // receive stream
    output logic rx_valid,
    output rawsk_pkg::rawsk_beat_type rx_beat,
    output rawsk_pkg::rawsk_rx_meta_type rx_meta,
    input wire logic rx_ready
);
    logic [7:0] txq[$];
    logic [1:0] tick = 2'h0;
    int last_at = 0;
    // slow pacing stalls three cycles in four
    assign tx_ready = !slow || tick == 2'h3;
    initial begin
        rx_valid = 1'b0;
        rx_beat = '0;
        rx_meta = '0;
    end
    always @(posedge pclk) begin
        tick <= tick + 2'h1;
        if (tx_valid && tx_ready) begin
            txq.push_back(tx_beat.data);
            if (tx_beat.last) last_at = txq.size();
        end
    end
    task automatic frame(input rawsk_pkg::rawsk_rx_meta_type m, input int n);
        int i;
        i = 0;
        rx_meta <= m;
        while (i < n) begin
            rx_valid <= 1'b1;
            rx_beat <= '{data: 8'(8'hA0 + i), last: (i == n - 1)};
            @(posedge pclk);
            if (rx_ready) i++;
        end
        // released lines show the inverse, not a stale copy
        rx_valid <= 1'b0;
        rx_beat <= ~rx_beat;
        rx_meta <= ~m;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### rawsk_socket_tb_top.sv
// bench: apb host tasks and scenarios against rawsk_socket
// assumes checker and network model compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "rawsk_defines.svh"
module rawsk_socket_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, tx_valid, tx_ready, rx_valid, rx_ready, hw_stack_take;
    rawsk_pkg::rawsk_beat_type tx_beat, rx_beat;
    rawsk_pkg::rawsk_rx_meta_type rx_meta;
    logic [7:0] q[$];
    logic [7:0] pl[4] = '{8'h11, 8'h06, 8'h02, 8'h01};
    int fail_count = 0, comparisons = 0, cycles = 0, takes = 0, t0;
    rawsk_socket rawsk_socket_i (.*);
    rawsk_mac_model rawsk_mac_model_i (.*);
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        takes += int'(hw_stack_take);
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic open(input logic [7:0] m, input logic [7:0] p, input logic [7:0] st);
        apb(1'b1, `RAWSK_A_CMD, 32'h10);
        apb(1'b1, `RAWSK_A_PROTO, {24'h0, p});
        apb(1'b1, `RAWSK_A_MODE, {24'h0, m});
        apb(1'b1, `RAWSK_A_CMD, 32'h01);
        chk_rd(`RAWSK_A_CMD, 32'h0);
        chk_rd(`RAWSK_A_STATE, {24'h0, st});
    endtask
    task automatic send_chk();
        apb(1'b1, `RAWSK_A_CMD, 32'h20);
        rd = 32'h0;
        while (rd[0] !== 1'b1) apb(1'b0, `RAWSK_A_IRQ, 32'h0);
        apb(1'b1, `RAWSK_A_IRQ, 32'h3);
        chk_rd(`RAWSK_A_IRQ, 32'h0);
        check(32'(rawsk_mac_model_i.txq.size()), 32'(q.size()));
        check(32'(rawsk_mac_model_i.last_at), 32'(q.size()));
        foreach (q[i]) check({24'h0, rawsk_mac_model_i.txq[i]}, {24'h0, q[i]});
        rawsk_mac_model_i.txq.delete();
    endtask
    task automatic rx(input logic [7:0] p, input logic [15:0] len, input logic [2:0] f);
        rawsk_mac_model_i.frame({32'h0A000002, p, len, f}, 4);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h030, 32'h0);
        check({31'h0, err}, 32'h1);
        foreach (pl[k]) open(8'h03, pl[k], pl[k] < 8'h06 ? 8'h32 : 8'h00);
        // a write while the enable is low must not land
        ce <= 1'b0;
        apb(1'b1, `RAWSK_A_PROTO, 32'h7);
        ce <= 1'b1;
        chk_rd(`RAWSK_A_PROTO, 32'h1);
        slow <= 1'b1;
        apb(1'b1, `RAWSK_A_DIP, 32'hC0A80105);
        for (int i = 0; i < 3; i++) apb(1'b1, 12'(12'h400 + 4 * i), 32'(8'h50 + i));
        apb(1'b1, `RAWSK_A_TXWR, 32'h3);
        q = '{8'hC0, 8'hA8, 8'h01, 8'h05, 8'h01, 8'h50, 8'h51, 8'h52};
        send_chk();
        chk_rd(`RAWSK_A_TXRD, 32'h3);
        rx(8'h01, 16'h0004, 3'h0);
        chk_rd(`RAWSK_A_RXSIZE, 32'hA);
        q = '{8'h0A, 8'h00, 8'h00, 8'h02, 8'h00, 8'h04, 8'hA0, 8'hA1, 8'hA2, 8'hA3};
        foreach (q[i]) chk_rd(12'(12'h800 + 4 * i), {24'h0, q[i]});
        chk_rd(`RAWSK_A_IRQ, 32'h2);
        t0 = takes;
        rx(8'h02, 16'h0004, 3'h0);
        rx(8'h01, 16'h0004, 3'h4);
        rx(8'h01, 16'h00FA, 3'h0);
        chk_rd(`RAWSK_A_RXSIZE, 32'hA);
        check(32'(takes - t0), 32'h3);
        open(8'h04, 8'h06, 8'h42);
        slow <= 1'b0;
        apb(1'b0, `RAWSK_A_TXRD, 32'h0);
        t0 = int'(rd[7:0]);
        q.delete();
        for (int i = 0; i < 14; i++) begin
            apb(1'b1, 12'(12'h400 + 4 * (t0 + i)), 32'(8'h11 + i));
            q.push_back(8'(8'h11 + i));
        end
        apb(1'b1, `RAWSK_A_TXWR, 32'(t0 + 14));
        while (q.size() < 60) q.push_back(8'h00);
        send_chk();
        open(8'h44, 8'h06, 8'h42);
        t0 = takes;
        rx(8'h01, 16'h0004, 3'h0);
        rx(8'h01, 16'h0004, 3'h1);
        check(32'(takes - t0), 32'h1);
        chk_rd(`RAWSK_A_IRQ, 32'h2);
        chk_rd(`RAWSK_A_RXSIZE, 32'h10);
        chk_rd(12'h82C, 32'h4);
        apb(1'b1, `RAWSK_A_RXRD, 32'h10);
        chk_rd(`RAWSK_A_RXSIZE, 32'h0);
        apb(1'b1, `RAWSK_A_CMD, 32'h40);
        chk_rd(`RAWSK_A_CMD, 32'h0);
        results();
    end
endmodule
`default_nettype wire
